// >>> design/station_block_pkg.sv
package station_block_pkg;

	// ==========================================================
	// Station block layout (byte indices)
	localparam int BLOCK_BYTES = 20;
	localparam int LOADED_BYTES = 12;
	localparam int BUFFER_OFFSET_IDX = 0;
	localparam int STATION_ADDRESS_IDX = 1;
	localparam int STATION_CONTROL_FLAGS_IDX = 3;
	localparam int NEXT_SEND_NUMBER_IDX = 4;
	localparam int ACKED_SEND_NUMBER_IDX = 6;
	localparam int ACCEPTED_RECEIVE_NUMBER_IDX = 7;
	localparam int BLOCK_IDENTIFIER_IDX = 8;
	localparam int RECEIVED_COMMAND_BYTE_IDX = 12;
	localparam int SENT_FRAME_COUNT_IDX = 14;
	localparam int RX_BUFFER_COUNT_IDX = 15;
	localparam int EXCEPTION_FLAGS_ONE_IDX = 18;
	localparam int EXCEPTION_FLAGS_TWO_IDX = 19;

	// ==========================================================
	// Field positions and values
	// Bit 7 of a flags byte is its most significant bit
	localparam int SKIP_BIT = 7;
	localparam int DATA_POLL_BIT = 6;
	localparam logic [7:0] MIN_BUFFER_OFFSET = 8'h02;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam int SENSE_INFO_BYTES = 24;

	// ==========================================================
	// Commands and frame kinds
	typedef enum logic [2:0] {
		CMD_POLL_TABLE = 3'h0,
		CMD_LOAD_BLOCK = 3'h1,
		CMD_READ_FRAME = 3'h2,
		CMD_WRITE_FRAME = 3'h3,
		CMD_POLL = 3'h4,
		CMD_BLOCK_SENSE = 3'h5,
		CMD_SENSE = 3'h6
	} command_type;

	typedef enum logic [1:0] {
		FRAME_READ = 2'h0,
		FRAME_WRITE = 2'h1,
		FRAME_POLL = 2'h2
	} frame_kind_type;

	typedef struct packed {
		command_type op;
		logic [23:0] data_address;
		logic [7:0] entry_count;
	} command_word_type;

	typedef struct packed {
		frame_kind_type kind;
		logic [23:0] buffer_address;
		logic [7:0] station_address;
		logic data_poll;
	} frame_request_type;

	typedef struct packed {
		logic data_check;
		logic command_reject;
	} completion_type;

	typedef struct packed {
		logic [7:0] received_command_byte;
		logic [7:0] sent_frame_count;
		logic [7:0] rx_buffer_count;
		logic [7:0] exception_flags_one;
		logic [7:0] exception_flags_two;
	} outcome_type;

endpackage

// >>> design/station_block_control.sv
`timescale 1ns/10ps
`default_nettype none

module station_block_control (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic cmd_valid_i,
	output logic cmd_ready_o,
	input wire station_block_pkg::command_word_type cmd_i,
	output logic cmd_done_o,
	output station_block_pkg::completion_type cmd_status_o,
	output logic mem_req_valid_o,
	input wire logic mem_req_ready_i,
	output logic [23:0] mem_req_address_o,
	input wire logic mem_rsp_valid_i,
	input wire logic [7:0] mem_rsp_data_i,
	output logic frame_req_valid_o,
	input wire logic frame_req_ready_i,
	output station_block_pkg::frame_request_type frame_req_o,
	input wire logic frame_done_i,
	input wire logic rx_address_valid_i,
	input wire logic [7:0] rx_address_i,
	input wire logic secondary_station_i,
	output logic frame_accept_o,
	output logic soft_error_o,
	input wire logic outcome_we_i,
	input wire station_block_pkg::outcome_type outcome_i,
	input wire logic [station_block_pkg::SENSE_INFO_BYTES*8-1:0] sense_info_i,
	output logic sense_valid_o,
	input wire logic sense_ready_i,
	output logic [7:0] sense_data_o,
	output logic block_valid_o,
	output logic station_active_o
);

	// ==========================================================
	// Reset release
	logic rst_meta_q;
	logic rst_sync_q;

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	// ==========================================================
	// State machine declarations
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_FETCH_REQ = 4'h1,
		ST_FETCH_DATA = 4'h2,
		ST_CHECK = 4'h3,
		ST_FRAME_REQ = 4'h4,
		ST_FRAME_WAIT = 4'h5,
		ST_SENSE_INFO = 4'h6,
		ST_SENSE_BLOCK = 4'h7,
		ST_DONE = 4'h8
	} state_type;

	state_type state_q, state_d;
	logic [7:0] block_q [0:station_block_pkg::BLOCK_BYTES-1];
	logic block_valid_q;
	logic table_mode_q;
	logic [7:0] entries_left_q;
	logic [23:0] fetch_address_q;
	logic [23:0] data_address_q;
	station_block_pkg::frame_kind_type frame_kind_q;
	logic [4:0] byte_count_q;
	station_block_pkg::completion_type status_q;
	logic done_q;

	function automatic logic [23:0] offset_address(input logic [23:0] base, input logic [7:0] off);
		offset_address = base + {16'h0000, off};
	endfunction

	// ==========================================================
	// Decoding
	wire logic cmd_take = cmd_valid_i && cmd_ready_o;
	wire logic [7:0] buffer_offset = block_q[station_block_pkg::BUFFER_OFFSET_IDX];
	wire logic [7:0] station_address = block_q[station_block_pkg::STATION_ADDRESS_IDX];
	wire logic [7:0] control_flags = block_q[station_block_pkg::STATION_CONTROL_FLAGS_IDX];
	wire logic station_skip = control_flags[station_block_pkg::SKIP_BIT];
	wire logic offset_bad = buffer_offset < station_block_pkg::MIN_BUFFER_OFFSET;
	wire logic is_load = cmd_i.op == station_block_pkg::CMD_POLL_TABLE ||
		cmd_i.op == station_block_pkg::CMD_LOAD_BLOCK;
	wire logic is_sense = cmd_i.op == station_block_pkg::CMD_BLOCK_SENSE ||
		cmd_i.op == station_block_pkg::CMD_SENSE;
	// frame commands need a current block
	wire logic needs_block = !is_load && !is_sense;
	wire logic reject_cmd = needs_block && !block_valid_q;
	wire logic load_byte = (state_q == ST_FETCH_DATA) && mem_rsp_valid_i;
	wire logic last_load_byte = load_byte &&
		(byte_count_q == 5'(station_block_pkg::LOADED_BYTES - 1));
	wire logic frame_issued = (state_q == ST_FRAME_REQ) && frame_req_ready_i;

	// ==========================================================
	// Two-entry sense buffer
	logic [7:0] fifo_q [0:1];
	logic fifo_rd_q;
	logic fifo_wr_q;
	logic [1:0] fifo_count_q;
	logic [7:0] push_data;
	wire logic sensing = (state_q == ST_SENSE_INFO) || (state_q == ST_SENSE_BLOCK);
	wire logic fifo_full = fifo_count_q == 2'h2;
	wire logic push = sensing && !fifo_full;
	wire logic pop = sense_valid_o && sense_ready_i;
	wire logic last_info_byte = byte_count_q ==
		5'(station_block_pkg::SENSE_INFO_BYTES - 1);
	wire logic last_block_byte = byte_count_q ==
		5'(station_block_pkg::BLOCK_BYTES - 1);

	// all twenty block bytes, after the 24 sense info bytes for CMD_SENSE
	always_comb begin
		if (state_q == ST_SENSE_INFO) begin
			push_data = sense_info_i[byte_count_q*8 +: 8];
		end else begin
			push_data = block_q[byte_count_q];
		end
	end

	assign sense_valid_o = fifo_count_q != 2'h0;
	assign sense_data_o = fifo_q[fifo_rd_q];

	always_ff @(posedge clock_i or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			fifo_q[0] <= station_block_pkg::BYTE_RESET;
			fifo_q[1] <= station_block_pkg::BYTE_RESET;
			fifo_rd_q <= 1'b0;
			fifo_wr_q <= 1'b0;
			fifo_count_q <= 2'h0;
		end else begin
			if (push) begin
				fifo_q[fifo_wr_q] <= push_data;
				fifo_wr_q <= !fifo_wr_q;
			end
			if (pop) begin
				fifo_rd_q <= !fifo_rd_q;
			end
			fifo_count_q <= fifo_count_q + {1'b0, push} - {1'b0, pop};
		end
	end

	// ==========================================================
	// Command sequencing
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (cmd_take) begin
					if (reject_cmd) begin
						state_d = ST_DONE;
					end else if (is_load) begin
						state_d = (cmd_i.op == station_block_pkg::CMD_POLL_TABLE &&
							cmd_i.entry_count == 8'h00) ? ST_DONE : ST_FETCH_REQ;
					end else if (cmd_i.op == station_block_pkg::CMD_BLOCK_SENSE) begin
						state_d = ST_SENSE_BLOCK;
					end else if (cmd_i.op == station_block_pkg::CMD_SENSE) begin
						state_d = ST_SENSE_INFO;
					end else if (cmd_i.op == station_block_pkg::CMD_POLL && station_skip) begin
						state_d = ST_DONE;
					end else begin
						state_d = ST_FRAME_REQ;
					end
				end
			end
			ST_FETCH_REQ: begin
				if (mem_req_ready_i) begin
					state_d = ST_FETCH_DATA;
				end
			end
			ST_FETCH_DATA: begin
				if (last_load_byte) begin
					state_d = ST_CHECK;
				end
			end
			ST_CHECK: begin
				if (offset_bad || (!table_mode_q)) begin
					state_d = ST_DONE;
				end else if (!station_skip) begin
					state_d = ST_FRAME_REQ;
				end else if (entries_left_q == 8'h01) begin
					state_d = ST_DONE;
				end else begin
					state_d = ST_FETCH_REQ;
				end
			end
			ST_FRAME_REQ: begin
				if (frame_issued) begin
					state_d = ST_FRAME_WAIT;
				end
			end
			ST_FRAME_WAIT: begin
				if (frame_done_i) begin
					if (table_mode_q && entries_left_q != 8'h01) begin
						state_d = ST_FETCH_REQ;
					end else begin
						state_d = ST_DONE;
					end
				end
			end
			ST_SENSE_INFO: begin
				if (push && last_info_byte) begin
					state_d = ST_SENSE_BLOCK;
				end
			end
			ST_SENSE_BLOCK: begin
				if (push && last_block_byte) begin
					state_d = ST_DONE;
				end
			end
			ST_DONE: begin
				state_d = ST_IDLE;
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_i or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			state_q <= ST_IDLE;
			table_mode_q <= 1'b0;
			entries_left_q <= 8'h00;
			fetch_address_q <= 24'h000000;
			data_address_q <= 24'h000000;
			frame_kind_q <= station_block_pkg::FRAME_POLL;
			byte_count_q <= 5'h00;
			block_valid_q <= 1'b0;
			status_q <= '0;
			done_q <= 1'b0;
		end else begin
			state_q <= state_d;
			done_q <= state_q == ST_DONE;
			if (cmd_take) begin
				table_mode_q <= cmd_i.op == station_block_pkg::CMD_POLL_TABLE;
				entries_left_q <= cmd_i.entry_count;
				fetch_address_q <= cmd_i.data_address;
				data_address_q <= cmd_i.data_address;
				byte_count_q <= 5'h00;
				status_q.command_reject <= reject_cmd;
				status_q.data_check <= 1'b0;
				case (cmd_i.op)
					station_block_pkg::CMD_READ_FRAME: frame_kind_q <= station_block_pkg::FRAME_READ;
					station_block_pkg::CMD_WRITE_FRAME: frame_kind_q <= station_block_pkg::FRAME_WRITE;
					default: frame_kind_q <= station_block_pkg::FRAME_POLL;
				endcase
			end
			if (state_q == ST_FETCH_REQ) begin
				byte_count_q <= 5'h00;
			end else if (load_byte || push) begin
				byte_count_q <= (push && state_q == ST_SENSE_INFO && last_info_byte) ?
					5'h00 : byte_count_q + 5'h01;
			end
			if (state_q == ST_CHECK) begin
				block_valid_q <= !offset_bad;
				status_q.data_check <= offset_bad;
			end
			if ((state_q == ST_FRAME_WAIT && frame_done_i) ||
				(state_q == ST_CHECK && !offset_bad && station_skip)) begin
				entries_left_q <= entries_left_q - 8'h01;
				fetch_address_q <= fetch_address_q + 24'(station_block_pkg::BLOCK_BYTES);
			end
		end
	end

	// ==========================================================
	// Current block storage
	always_ff @(posedge clock_i or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			for (int i = 0; i < station_block_pkg::BLOCK_BYTES; i++) begin
				block_q[i] <= station_block_pkg::BYTE_RESET;
			end
		end else begin
			if (load_byte) begin
				block_q[byte_count_q] <= mem_rsp_data_i;
			end
			// outcome bytes come from the line side only
			if (state_q == ST_FETCH_REQ) begin
				for (int i = station_block_pkg::LOADED_BYTES; i < station_block_pkg::BLOCK_BYTES;
					i++) begin
					block_q[i] <= station_block_pkg::BYTE_RESET;
				end
			end else if (outcome_we_i) begin
				block_q[station_block_pkg::RECEIVED_COMMAND_BYTE_IDX] <= outcome_i.received_command_byte;
				block_q[station_block_pkg::SENT_FRAME_COUNT_IDX] <= outcome_i.sent_frame_count;
				block_q[station_block_pkg::RX_BUFFER_COUNT_IDX] <= outcome_i.rx_buffer_count;
				block_q[station_block_pkg::EXCEPTION_FLAGS_ONE_IDX] <= outcome_i.exception_flags_one;
				block_q[station_block_pkg::EXCEPTION_FLAGS_TWO_IDX] <= outcome_i.exception_flags_two;
			end
			// loaded fields held until next load
		end
	end

	// ==========================================================
	// Inbound address check
	logic accept_q;
	logic soft_error_q;
	wire logic address_match = block_valid_q && (rx_address_i == station_address);

	always_ff @(posedge clock_i or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			accept_q <= 1'b0;
			soft_error_q <= 1'b0;
		end else begin
			accept_q <= rx_address_valid_i && address_match;
			soft_error_q <= rx_address_valid_i && !address_match && !secondary_station_i;
		end
	end

	// ==========================================================
	// Outputs
	// Held low until the reset copy releases, so no command is taken and then lost
	assign cmd_ready_o = rst_sync_q && (state_q == ST_IDLE);
	assign cmd_done_o = done_q;
	assign cmd_status_o = status_q;
	assign mem_req_valid_o = state_q == ST_FETCH_REQ;
	assign mem_req_address_o = fetch_address_q;
	assign frame_req_valid_o = state_q == ST_FRAME_REQ;
	assign frame_accept_o = accept_q;
	assign soft_error_o = soft_error_q;
	assign block_valid_o = block_valid_q;
	assign station_active_o = block_valid_q && !station_skip;

	// offset added for every frame kind
	assign frame_req_o.buffer_address = offset_address(data_address_q, buffer_offset);
	assign frame_req_o.kind = table_mode_q ? station_block_pkg::FRAME_POLL : frame_kind_q;
	assign frame_req_o.station_address = station_address;
	assign frame_req_o.data_poll = control_flags[station_block_pkg::DATA_POLL_BIT];

endmodule

`default_nettype wire

// >>> verif/station_block_control_assertions.sv
`timescale 1ns/10ps
`default_nettype none

module station_block_control_assertions (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic cmd_valid_i,
	input wire logic cmd_ready_o,
	input wire station_block_pkg::command_word_type cmd_i,
	input wire logic cmd_done_o,
	input wire station_block_pkg::completion_type cmd_status_o,
	input wire logic mem_req_valid_o,
	input wire logic mem_req_ready_i,
	input wire logic [23:0] mem_req_address_o,
	input wire logic frame_req_valid_o,
	input wire logic frame_req_ready_i,
	input wire station_block_pkg::frame_request_type frame_req_o,
	input wire logic rx_address_valid_i,
	input wire logic secondary_station_i,
	input wire logic frame_accept_o,
	input wire logic soft_error_o,
	input wire logic sense_valid_o,
	input wire logic sense_ready_i,
	input wire logic [7:0] sense_data_o,
	input wire logic block_valid_o,
	input wire logic station_active_o
);
	logic take;
	logic frame_cmd;
	logic fetch_cmd;
	logic [23:0] addr_q;
	logic [23:0] gap;

	// ==========
	// Helpers
	assign take = cmd_valid_i && cmd_ready_o;
	assign frame_cmd = cmd_i.op inside {station_block_pkg::CMD_READ_FRAME,
		station_block_pkg::CMD_WRITE_FRAME, station_block_pkg::CMD_POLL};
	assign fetch_cmd = cmd_i.op == station_block_pkg::CMD_LOAD_BLOCK ||
		(cmd_i.op == station_block_pkg::CMD_POLL_TABLE && cmd_i.entry_count != 8'h00);
	// Wraps at 24 bits like the buffer address itself
	assign gap = frame_req_o.buffer_address - addr_q;

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			addr_q <= 24'h000000;
		end else if (take) begin
			addr_q <= cmd_i.data_address;
		end
	end

	// ==========
	// Properties
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);

	reject_no_block_a: assert property (
		take && frame_cmd && !block_valid_o |->
		!frame_req_valid_o [*2] ##1 cmd_done_o && cmd_status_o.command_reject
	) else $error("frame command without block not rejected");
	fetch_start_a: assert property (
		take && fetch_cmd |=> mem_req_valid_o && mem_req_address_o == $past(cmd_i.data_address)
	) else $error("block fetch not started at command address");
	fetch_hold_a: assert property (
		mem_req_valid_o && !mem_req_ready_i |=> mem_req_valid_o && $stable(mem_req_address_o)
	) else $error("storage request dropped or moved while waiting");
	frame_hold_a: assert property (
		frame_req_valid_o && !frame_req_ready_i |=> frame_req_valid_o && $stable(frame_req_o)
	) else $error("frame request changed while waiting");
	offset_range_a: assert property (
		frame_req_valid_o && frame_req_o.kind != station_block_pkg::FRAME_POLL |->
		gap >= 24'h000002 && gap <= 24'h0000FF
	) else $error("data frame offset outside legal range");
	skip_no_poll_a: assert property (
		frame_req_valid_o && frame_req_o.kind == station_block_pkg::FRAME_POLL |-> station_active_o
	) else $error("inactive station polled");
	primary_answer_a: assert property (
		rx_address_valid_i && !secondary_station_i |=> frame_accept_o != soft_error_o
	) else $error("primary address check gave no single answer");
	secondary_quiet_a: assert property (
		rx_address_valid_i && secondary_station_i |=> !soft_error_o
	) else $error("soft error raised as secondary");
	sense_start_a: assert property (
		take && cmd_i.op == station_block_pkg::CMD_BLOCK_SENSE |-> ##2 sense_valid_o
	) else $error("block sense first byte late");
	sense_hold_a: assert property (
		sense_valid_o && !sense_ready_i |=> sense_valid_o && $stable(sense_data_o)
	) else $error("sense byte lost during stall");
endmodule

bind station_block_control station_block_control_assertions i_station_block_control_assertions (
	.clock_i, .rst_n_i, .cmd_valid_i, .cmd_ready_o, .cmd_i, .cmd_done_o, .cmd_status_o,
	.mem_req_valid_o, .mem_req_ready_i, .mem_req_address_o, .frame_req_valid_o,
	.frame_req_ready_i, .frame_req_o, .rx_address_valid_i, .secondary_station_i,
	.frame_accept_o, .soft_error_o, .sense_valid_o, .sense_ready_i, .sense_data_o,
	.block_valid_o, .station_active_o
);

`default_nettype wire

// >>> verif/channel_partner_model.sv
`timescale 1ns/10ps
`default_nettype none

module channel_partner_model (
	input wire logic clock_i,
	input wire logic slow_i,
	input wire logic req_valid_i,
	input wire logic [23:0] req_address_i,
	output logic req_ready_o,
	output logic rsp_valid_o,
	output logic [7:0] rsp_data_o,
	input wire logic frame_valid_i,
	output logic frame_ready_o,
	output logic frame_done_o
);
	logic [7:0] mem [256];
	logic [23:0] base;

	initial begin
		req_ready_o = 1'b0;
		rsp_valid_o = 1'b0;
		rsp_data_o = 8'h00;
		frame_ready_o = 1'b0;
		frame_done_o = 1'b0;
	end

	// ==========
	// Storage
	// twelve bytes only
	always begin
		@(posedge clock_i);
		if (req_valid_i === 1'b1) begin
			base = req_address_i;
			if (slow_i) repeat (2) @(posedge clock_i);
			req_ready_o <= 1'b1;
			@(posedge clock_i);
			req_ready_o <= 1'b0;
			for (int k = 0; k < 12; k++) begin
				rsp_valid_o <= 1'b1;
				rsp_data_o <= mem[base[7:0] + k[7:0]];
				@(posedge clock_i);
				if (slow_i) begin
					rsp_valid_o <= 1'b0;
					rsp_data_o <= ~rsp_data_o;
					@(posedge clock_i);
				end
			end
			rsp_valid_o <= 1'b0;
			// Idle data is scrambled so a stale byte never looks valid
			rsp_data_o <= ~rsp_data_o;
		end
	end

	// ==========
	// Line side
	always begin
		@(posedge clock_i);
		if (frame_valid_i === 1'b1) begin
			if (slow_i) repeat (3) @(posedge clock_i);
			frame_ready_o <= 1'b1;
			@(posedge clock_i);
			frame_ready_o <= 1'b0;
			repeat (slow_i ? 6 : 2) @(posedge clock_i);
			frame_done_o <= 1'b1;
			@(posedge clock_i);
			frame_done_o <= 1'b0;
		end
	end
endmodule

`default_nettype wire

// >>> verif/station_block_control_tb.sv
`timescale 1ns/10ps
`default_nettype none

`define CHECK(name, exp, got) \
	begin \
		tests_run++; \
		if ((got) !== (exp)) begin \
			error_cnt++; \
			$display("BAD %s expected %0h seen %0h", name, (exp), (got)); \
		end \
	end

module station_block_control_tb;
	logic clock_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic cmd_valid_i = 1'b0;
	station_block_pkg::command_word_type cmd_i = '0;
	logic rx_address_valid_i = 1'b0;
	logic [7:0] rx_address_i = 8'h00;
	logic secondary_station_i = 1'b0;
	logic outcome_we_i = 1'b0;
	station_block_pkg::outcome_type outcome_i = '0;
	logic [station_block_pkg::SENSE_INFO_BYTES*8-1:0] sense_info_i;
	logic sense_ready_i = 1'b0;
	logic slow = 1'b0;
	logic cmd_ready_o, cmd_done_o, mem_req_valid_o, mem_req_ready_i, mem_rsp_valid_i;
	logic frame_req_valid_o, frame_req_ready_i, frame_done_i, frame_accept_o, soft_error_o;
	logic sense_valid_o, block_valid_o, station_active_o;
	logic [23:0] mem_req_address_o;
	logic [7:0] mem_rsp_data_i, sense_data_o;
	station_block_pkg::completion_type cmd_status_o;
	station_block_pkg::frame_request_type frame_req_o;
	int error_cnt = 0;
	int tests_run = 0;
	int cyc = 0;
	logic [7:0] blk [20];
	logic [7:0] sq [$];
	station_block_pkg::frame_request_type fq [$];
	logic [7:0] offs [4] = '{8'h00, 8'h01, 8'h02, 8'hFF};
	station_block_pkg::command_type ops [3] = '{station_block_pkg::CMD_READ_FRAME,
		station_block_pkg::CMD_WRITE_FRAME, station_block_pkg::CMD_POLL};
	station_block_pkg::frame_kind_type kinds [3] = '{station_block_pkg::FRAME_READ,
		station_block_pkg::FRAME_WRITE, station_block_pkg::FRAME_POLL};

	station_block_control i_station_block_control (
		.clock_i, .rst_n_i, .cmd_valid_i, .cmd_ready_o, .cmd_i, .cmd_done_o, .cmd_status_o,
		.mem_req_valid_o, .mem_req_ready_i, .mem_req_address_o, .mem_rsp_valid_i,
		.mem_rsp_data_i, .frame_req_valid_o, .frame_req_ready_i, .frame_req_o, .frame_done_i,
		.rx_address_valid_i, .rx_address_i, .secondary_station_i, .frame_accept_o,
		.soft_error_o, .outcome_we_i, .outcome_i, .sense_info_i, .sense_valid_o,
		.sense_ready_i, .sense_data_o, .block_valid_o, .station_active_o
	);
	channel_partner_model i_channel_partner_model (
		.clock_i, .slow_i(slow), .req_valid_i(mem_req_valid_o), .req_address_i(mem_req_address_o),
		.req_ready_o(mem_req_ready_i), .rsp_valid_o(mem_rsp_valid_i), .rsp_data_o(mem_rsp_data_i),
		.frame_valid_i(frame_req_valid_o), .frame_ready_o(frame_req_ready_i),
		.frame_done_o(frame_done_i)
	);

	// ==========
	// Clock, watchdog, monitors
	always #10 clock_i = ~clock_i;
	always @(posedge clock_i) begin
		cyc++;
		if (sense_valid_o === 1'b1 && sense_ready_i === 1'b1) sq.push_back(sense_data_o);
		if (frame_req_valid_o === 1'b1 && frame_req_ready_i === 1'b1) fq.push_back(frame_req_o);
		if (cyc == 20000) begin
			error_cnt++;
			summarize();
		end
	end
	// Stall one cycle in three so the buffer fills
	always @(negedge clock_i) sense_ready_i <= (cyc % 3) != 0;

	// ==========
	// Tasks
	task automatic summarize();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic run(input station_block_pkg::command_type op, input logic [23:0] a,
		input logic [7:0] n);
		int t;
		t = 0;
		@(negedge clock_i);
		cmd_i = '{op, a, n};
		cmd_valid_i = 1'b1;
		while (cmd_ready_o !== 1'b1) @(negedge clock_i);
		@(negedge clock_i);
		cmd_valid_i = 1'b0;
		while (cmd_done_o !== 1'b1 && t < 400) begin
			@(negedge clock_i);
			t++;
		end
		`CHECK("done", 1'b1, cmd_done_o)
	endtask

	task automatic put(input logic [7:0] b, input logic [7:0] off, input logic [7:0] adr,
		input logic [7:0] flg);
		for (int k = 0; k < 20; k++) blk[k] = (k < 12) ? 8'h10 + k[7:0] : 8'h00;
		blk[0] = off;
		blk[1] = adr;
		blk[2] = 8'h00;
		blk[3] = flg;
		blk[5] = 8'h00;
		for (int k = 0; k < 20; k++) i_channel_partner_model.mem[b + k[7:0]] = (k < 12) ? blk[k] : 8'hEE;
	endtask

	task automatic sense(input station_block_pkg::command_type op, input int pre);
		int t;
		t = 0;
		sq.delete();
		run(op, 24'h000100, 8'h00);
		while (sq.size() < pre + 20 && t < 200) begin
			@(negedge clock_i);
			t++;
		end
		`CHECK("sense count", pre + 20, sq.size())
		for (int k = 0; k < pre + 20; k++) begin
			`CHECK("sense byte", (k < pre) ? sense_info_i[8*k+:8] : blk[k-pre], sq[k])
		end
	endtask

	task automatic addr(input logic [7:0] a, input logic sec, input logic [1:0] exp);
		@(negedge clock_i);
		secondary_station_i = sec;
		rx_address_valid_i = 1'b1;
		rx_address_i = a;
		@(negedge clock_i);
		rx_address_valid_i = 1'b0;
		`CHECK("address answer", exp, {frame_accept_o, soft_error_o})
	endtask

	// ==========
	// Sequence
	initial begin
		for (int k = 0; k < 24; k++) sense_info_i[8*k+:8] = 8'h30 + k[7:0];
		repeat (16) @(posedge clock_i);
		@(negedge clock_i);
		rst_n_i = 1'b1;
		run(station_block_pkg::CMD_POLL, 24'h000000, 8'h00);
		`CHECK("reject", 2'b01, cmd_status_o)
		foreach (offs[i]) begin
			put(8'h40, offs[i], 8'hC1, 8'h00);
			run(station_block_pkg::CMD_LOAD_BLOCK, 24'h000040, 8'h00);
			`CHECK("load status", {offs[i] < 2, 1'b0}, cmd_status_o)
			`CHECK("block valid", offs[i] > 1, block_valid_o)
			if (offs[i] > 1) begin
				fq.delete();
				for (int j = 0; j < 3; j++) begin
					run(ops[j], 24'hFFFFF0, 8'h00);
					`CHECK("frame kind", kinds[j], fq[j].kind)
					`CHECK("frame station", 8'hC1, fq[j].station_address)
				end
				`CHECK("read buffer", 24'hFFFFF0 + offs[i], fq[0].buffer_address)
				`CHECK("write buffer", 24'hFFFFF0 + offs[i], fq[1].buffer_address)
				`CHECK("contact poll", 1'b0, fq[2].data_poll)
			end
		end
		addr(8'hC1, 1'b0, 2'b10);
		addr(8'h22, 1'b0, 2'b01);
		addr(8'h22, 1'b1, 2'b00);
		addr(8'hC1, 1'b1, 2'b10);
		@(negedge clock_i);
		outcome_i = '{8'hA1, 8'hA2, 8'hA3, 8'hA4, 8'hA5};
		outcome_we_i = 1'b1;
		@(negedge clock_i);
		outcome_we_i = 1'b0;
		blk[12] = 8'hA1;
		blk[14] = 8'hA2;
		blk[15] = 8'hA3;
		blk[18] = 8'hA4;
		blk[19] = 8'hA5;
		sense(station_block_pkg::CMD_BLOCK_SENSE, 0);
		sense(station_block_pkg::CMD_SENSE, 24);
		put(8'h40, 8'h02, 8'hC1, 8'h80);
		run(station_block_pkg::CMD_LOAD_BLOCK, 24'h000040, 8'h00);
		`CHECK("skip inactive", 1'b0, station_active_o)
		fq.delete();
		run(station_block_pkg::CMD_POLL, 24'h000000, 8'h00);
		`CHECK("skip no poll", 0, fq.size())
		slow = 1'b1;
		put(8'h80, 8'h02, 8'hA0, 8'h40);
		put(8'h94, 8'h03, 8'hB0, 8'h80);
		put(8'hA8, 8'h04, 8'hA2, 8'h00);
		run(station_block_pkg::CMD_POLL_TABLE, 24'h000080, 8'h03);
		`CHECK("table polls", 2, fq.size())
		`CHECK("first station", 8'hA0, fq[0].station_address)
		`CHECK("data poll", 1'b1, fq[0].data_poll)
		`CHECK("third station", 8'hA2, fq[1].station_address)
		`CHECK("contact poll", 1'b0, fq[1].data_poll)
		sense(station_block_pkg::CMD_BLOCK_SENSE, 0);
		summarize();
	end
endmodule

`default_nettype wire
